// [afe_defs.vh]
`ifndef AFE_DEFS_VH
`define AFE_DEFS_VH

// AHB register byte offsets
`define AFE_CFG_OFFSET      8'h00
`define AFE_STAT_OFFSET     8'h04

// Serial port register index of the sample mode register
`define AFE_SER_CFG_INDEX   7'h00

// Sample mode register fields
`define AFE_CFG_SLOW_SLEW   0
`define AFE_CFG_EDGE_SEL    1
`define AFE_CFG_CDS_EN      2
`define AFE_CFG_CLAMP_PHASE 3
`define AFE_CFG_WIDTH       4
`define AFE_CFG_RESET       4'h0

// Status register fields
`define AFE_STAT_DIV_LSB    0
`define AFE_STAT_DIV_MSB    3
`define AFE_STAT_CLAMP      4
`define AFE_STAT_LVL_LSB    5
`define AFE_STAT_LVL_MSB    10

// Serial frame: read flag, 7 index bits, 8 data bits
`define AFE_SER_FRAME_BITS  5'h10
`define AFE_SER_HEAD_BITS   5'h08

// Conversion result and output stream
`define AFE_RESULT_WIDTH    14
`define AFE_FIFO_DEPTH      32

`endif

// [afe_clamp_and_sample_mode_control.v]
// The implementer's own choices: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
`include "afe_defs.vh"

module sample_fifo
#(
   parameter WIDTH = 14,
   parameter DEPTH = 32,
   parameter AW    = 5
)
(
   // Clock and reset
   input  wire             hclk,
   input  wire             hresetn,
   // Fill side
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // Drain side
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data,
   // Fill level
   output wire [AW:0]      level
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0]      wr_ptr_reg;
   reg [AW:0]      rd_ptr_reg;
   wire            do_write;
   wire            do_read;
   assign level     = wr_ptr_reg - rd_ptr_reg;
   assign in_ready  = (level != DEPTH[AW:0]);
   assign out_valid = (level != {(AW+1){1'b0}});
   assign out_data  = mem[rd_ptr_reg[AW-1:0]];
   assign do_write  = in_valid & in_ready;
   assign do_read   = out_valid & out_ready;
   always @(posedge hclk)
   begin
      if (do_write)
      begin
         mem[wr_ptr_reg[AW-1:0]] <= in_data;
      end
   end
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_ptr_reg <= {(AW+1){1'b0}};
         rd_ptr_reg <= {(AW+1){1'b0}};
      end
      else
      begin
         if (do_write)
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (do_read)
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
   end
endmodule // sample_fifo

module afe_clamp_and_sample_mode_control
(
   // Clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   // AHB-Lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output wire        hreadyout,
   output wire        hresp,
   // Timing pins from the scanner controller
   input  wire        pixel_clock_in,
   input  wire        sample_strobe,
   input  wire        clamp_request,
   // Serial port pins
   input  wire        serial_frame_enable,
   input  wire        serial_shift_clock,
   input  wire        serial_data_in,
   output reg         serial_data_out,
   output reg         serial_data_out_oe,
   // Conversion results from the converter core
   input  wire [13:0] adc_result,
   input  wire        adc_valid,
   output wire        adc_ready,
   // Analog control
   output reg         clamp_active,
   output wire        cds_enable,
   output wire        output_slow_slew,
   // Output data pins
   output reg  [7:0]  output_byte_pins,
   output reg         output_high_byte
);
   // Synchronisers: pclk, strobe, clamp, sen, sclk, sdi
   reg  [5:0]  sync1_reg;
   reg  [5:0]  sync2_reg;
   reg         pclk_prev_reg;
   wire        pclk_s   = sync2_reg[0];
   wire        strobe_s = sync2_reg[1];
   wire        clamp_s  = sync2_reg[2];
   wire        sen_s    = sync2_reg[3];
   wire        sclk_s   = sync2_reg[4];
   wire        sdi_s    = sync2_reg[5];
   wire        mclk_rise = pclk_s & ~pclk_prev_reg;
   wire        mclk_fall = ~pclk_s & pclk_prev_reg;

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sync1_reg     <= 6'h00;
         sync2_reg     <= 6'h00;
         pclk_prev_reg <= 1'b0;
      end
      else
      begin
         sync1_reg     <= {serial_data_in, serial_shift_clock, serial_frame_enable,
                           clamp_request, sample_strobe, pixel_clock_in};
         sync2_reg     <= sync1_reg;
         pclk_prev_reg <= pclk_s;
      end
   end
   // Sample mode register, shared by AHB and serial port
   reg  [3:0]  cfg_reg;
   wire        edge_sel    = cfg_reg[`AFE_CFG_EDGE_SEL];
   wire        clamp_phase = cfg_reg[`AFE_CFG_CLAMP_PHASE];
   assign cds_enable       = cfg_reg[`AFE_CFG_CDS_EN];
   assign output_slow_slew = cfg_reg[`AFE_CFG_SLOW_SLEW];

   // Pixel timing: divide ratio measured between strobe rises
   reg  [3:0]  mclk_idx_reg;
   reg  [3:0]  div_reg;
   reg         strobe_prev_reg;
   reg         clamp_armed_reg;
   reg         clamp_pixel_reg;
   wire        pixel_start = mclk_rise & strobe_s & ~strobe_prev_reg;
   wire [3:0]  idx_now = pixel_start ? 4'h0 : mclk_idx_reg + 4'h1;
   wire        clamp_now = pixel_start ? clamp_armed_reg : clamp_pixel_reg;
   wire [3:0]  half_div = {1'b0, div_reg[3:1]};

   // Clamp window within the pixel for the given phase and index
   function clamp_window;
      input       phase;
      input [3:0] idx;
      input [3:0] half;
      begin
         if (phase)
            clamp_window = (idx >= 4'h1) && (idx <= half);
         else
            clamp_window = (idx == 4'h0);
      end
   endfunction

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         mclk_idx_reg    <= 4'h0;
         div_reg         <= 4'h2;
         strobe_prev_reg <= 1'b0;
         clamp_armed_reg <= 1'b0;
         clamp_pixel_reg <= 1'b0;
         clamp_active    <= 1'b0;
      end
      else if (mclk_rise)
      begin
         strobe_prev_reg <= strobe_s;
         if (pixel_start || mclk_idx_reg != 4'hF)
            mclk_idx_reg <= idx_now;
         if (pixel_start)
         begin
            div_reg         <= (mclk_idx_reg == 4'hF) ? 4'hF : mclk_idx_reg + 4'h1;
            clamp_pixel_reg <= clamp_armed_reg;
            clamp_armed_reg <= clamp_s;
         end
         clamp_active <= clamp_now & clamp_window(clamp_phase, idx_now, half_div);
      end
   end
   // Serial port, advanced only on pixel clock rising edges
   reg         sen_prev_reg;
   reg         sclk_prev_reg;
   reg  [4:0]  bit_cnt_reg;
   reg  [14:0] shift_in_reg;
   reg  [7:0]  shift_out_reg;
   reg         ser_read_reg;
   reg         ser_write_reg;
   reg  [3:0]  ser_wdata_reg;
   wire        sclk_rise = sclk_s & ~sclk_prev_reg;
   wire [15:0] frame_bits = {shift_in_reg, sdi_s};

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sen_prev_reg       <= 1'b0;
         sclk_prev_reg      <= 1'b0;
         bit_cnt_reg        <= 5'h00;
         shift_in_reg       <= 15'h0000;
         shift_out_reg      <= 8'h00;
         ser_read_reg       <= 1'b0;
         ser_write_reg      <= 1'b0;
         ser_wdata_reg      <= 4'h0;
         serial_data_out    <= 1'b0;
         serial_data_out_oe <= 1'b0;
      end
      else
      begin
         ser_write_reg <= 1'b0;
         if (mclk_rise)
         begin
            sen_prev_reg  <= sen_s;
            sclk_prev_reg <= sclk_s;
            if (!sen_s)
            begin
               bit_cnt_reg        <= 5'h00;
               ser_read_reg       <= 1'b0;
               serial_data_out_oe <= 1'b0;
            end
            else if (sclk_rise && bit_cnt_reg != `AFE_SER_FRAME_BITS)
            begin
               shift_in_reg <= frame_bits[14:0];
               bit_cnt_reg  <= bit_cnt_reg + 5'h01;
               if (bit_cnt_reg == `AFE_SER_HEAD_BITS - 5'h01)
               begin
                  ser_read_reg       <= frame_bits[7];
                  serial_data_out_oe <= frame_bits[7];
                  shift_out_reg      <= (frame_bits[6:0] == `AFE_SER_CFG_INDEX) ?
                                        {4'h0, cfg_reg} : 8'h00;
               end
               else if (ser_read_reg)
               begin
                  serial_data_out <= shift_out_reg[7];
                  shift_out_reg   <= {shift_out_reg[6:0], 1'b0};
               end
               if (bit_cnt_reg == `AFE_SER_FRAME_BITS - 5'h01 && !frame_bits[15] &&
                   frame_bits[14:8] == `AFE_SER_CFG_INDEX)
               begin
                  ser_write_reg <= 1'b1;
                  ser_wdata_reg <= frame_bits[3:0];
               end
            end
         end
      end
   end
   // AHB-Lite slave, zero wait states
   reg         ahb_wr_reg;
   reg  [7:0]  ahb_addr_reg;
   wire        ahb_take = hsel & hready & htrans[1];
   wire [5:0]  fifo_level;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ahb_wr_reg   <= 1'b0;
         ahb_addr_reg <= 8'h00;
         hrdata       <= 32'h00000000;
         cfg_reg      <= `AFE_CFG_RESET;
      end
      else
      begin
         ahb_wr_reg <= ahb_take & hwrite;
         if (ahb_take)
            ahb_addr_reg <= haddr[7:0];
         if (ahb_take && !hwrite)
         begin
            case (haddr[7:0])
               `AFE_CFG_OFFSET:  hrdata <= {28'h0000000, cfg_reg};
               `AFE_STAT_OFFSET: hrdata <= {21'h000000, fifo_level, clamp_active, div_reg};
               default:          hrdata <= 32'h00000000;
            endcase
         end
         if (ser_write_reg)
            cfg_reg <= ser_wdata_reg;
         else if (ahb_wr_reg && ahb_addr_reg == `AFE_CFG_OFFSET)
            cfg_reg <= hwdata[3:0];
      end
   end
   // Result FIFO and byte output
   wire        fifo_valid;
   wire [13:0] fifo_data;
   reg  [5:0]  low_bits_reg;
   wire        out_edge = edge_sel ? mclk_rise : mclk_fall;
   wire        fifo_pop = out_edge & ~output_high_byte & fifo_valid;
   sample_fifo #(.WIDTH (`AFE_RESULT_WIDTH), .DEPTH (`AFE_FIFO_DEPTH), .AW (5)) u_fifo
   (
      .hclk (hclk), .hresetn (hresetn), .in_valid (adc_valid), .in_ready (adc_ready),
      .in_data (adc_result), .out_valid (fifo_valid), .out_ready (fifo_pop),
      .out_data (fifo_data), .level (fifo_level)
   );
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         output_byte_pins <= 8'h00;
         output_high_byte <= 1'b0;
         low_bits_reg     <= 6'h00;
      end
      else if (out_edge)
      begin
         if (output_high_byte)
         begin
            output_byte_pins <= {low_bits_reg, 2'b00};
            output_high_byte <= 1'b0;
         end
         else if (fifo_valid)
         begin
            output_byte_pins <= fifo_data[13:6];
            low_bits_reg     <= fifo_data[5:0];
            output_high_byte <= 1'b1;
         end
      end
   end
endmodule // afe_clamp_and_sample_mode_control

// [afe_ctrl_props.sv]
`timescale 1ns/10ps
module afe_ctrl_props
(
   // Clock and reset
   input wire       hclk,
   input wire       hresetn,
   // Timing and serial pins
   input wire       pixel_clock_in,
   input wire       sample_strobe,
   input wire       clamp_request,
   input wire       serial_frame_enable,
   input wire       serial_shift_clock,
   input wire       serial_data_out,
   input wire       serial_data_out_oe,
   // Clamp and output pins
   input wire       clamp_active,
   input wire [7:0] output_byte_pins,
   input wire       output_high_byte
);
   logic [8:0] arm_age;
   logic       pclk_d;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Cycles since a pixel clock rise saw request and strobe together
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         arm_age <= 9'h12C;
         pclk_d  <= 1'b0;
      end
      else
      begin
         pclk_d <= pixel_clock_in;
         if (pixel_clock_in && !pclk_d && clamp_request && sample_strobe)
            arm_age <= 9'h000;
         else if (arm_age < 9'h12C)
            arm_age <= arm_age + 9'h001;
      end
   end
   property p_clamp_cause; $rose(clamp_active) |-> arm_age < 9'h12C; endproperty
   a_clamp_cause: assert property (p_clamp_cause) else $error("clamp cause");
   property p_clamp_min; $rose(clamp_active) |-> clamp_active [*7]; endproperty
   a_clamp_min: assert property (p_clamp_min) else $error("clamp short");
   property p_clamp_ends; $rose(clamp_active) |-> ##[7:130] !clamp_active; endproperty
   a_clamp_ends: assert property (p_clamp_ends) else $error("clamp long");
   property p_low_byte; !output_high_byte |-> output_byte_pins[1:0] == 2'h0; endproperty
   a_low_byte: assert property (p_low_byte) else $error("low byte pad");
   property p_byte_flag; $changed(output_byte_pins) |-> $changed(output_high_byte); endproperty
   a_byte_flag: assert property (p_byte_flag) else $error("byte order");
   property p_byte_hold; $changed(output_high_byte) |=> $stable(output_high_byte) [*6]; endproperty
   a_byte_hold: assert property (p_byte_hold) else $error("byte hold");
   property p_oe_drop; $fell(serial_frame_enable) |-> ##[1:16] !serial_data_out_oe; endproperty
   a_oe_drop: assert property (p_oe_drop) else $error("oe after frame");
   property p_sdo_shift;
      serial_data_out_oe && $past(serial_data_out_oe) && $changed(serial_data_out)
         |-> serial_shift_clock;
   endproperty
   a_sdo_shift: assert property (p_sdo_shift) else $error("sdo timing");
endmodule // afe_ctrl_props

bind afe_clamp_and_sample_mode_control afe_ctrl_props u_afe_ctrl_props
(
   .hclk(hclk), .hresetn(hresetn), .pixel_clock_in(pixel_clock_in),
   .sample_strobe(sample_strobe), .clamp_request(clamp_request),
   .serial_frame_enable(serial_frame_enable), .serial_shift_clock(serial_shift_clock),
   .serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe),
   .clamp_active(clamp_active), .output_byte_pins(output_byte_pins),
   .output_high_byte(output_high_byte)
);

// [scan_ctrl_model.sv]
`timescale 1ns/10ps
module scan_ctrl_model
(
   // Timing pins
   output logic pixel_clock_in      = 1'b0,
   output logic sample_strobe       = 1'b0,
   output logic clamp_request       = 1'b0,
   // Serial port
   output logic serial_frame_enable = 1'b0,
   output logic serial_shift_clock  = 1'b0,
   output logic serial_data_in      = 1'b0,
   input  wire  serial_data_out,
   input  wire  serial_data_out_oe
);
   int div      = 2;
   bit clamp_on = 1'b0;
   int last_div = 0;
   int idx      = 0;
   // Free running pixel clock, serial frames included
   always #100 pixel_clock_in = ~pixel_clock_in;
   // Strobe and request move on the fall, quiet for 3 clocks on a mode change
   always @(negedge pixel_clock_in)
   begin
      if (div != last_div)
      begin
         last_div = div;
         idx      = -3;
      end
      sample_strobe <= (idx == 0);
      clamp_request <= clamp_on && idx >= 0;
      idx = (idx == div - 1) ? 0 : idx + 1;
   end
   // One frame, shift clock half period of two pixel clocks
   task ser_frame(input logic [15:0] frame, output logic [7:0] rdata);
      @(negedge pixel_clock_in);
      serial_frame_enable = 1'b1;
      for (int k = 15; k >= 0; k--)
      begin
         serial_data_in = frame[k];
         repeat (2) @(negedge pixel_clock_in);
         serial_shift_clock = 1'b1;
         repeat (2) @(negedge pixel_clock_in);
         // Read bits move after the shift clock rise, so take them late in the high phase
         if (k < 8)
            rdata[k] = serial_data_out_oe ? serial_data_out : ~serial_data_out;
         serial_shift_clock = 1'b0;
      end
      serial_frame_enable = 1'b0;
      serial_data_in      = ~serial_data_in;
      repeat (4) @(negedge pixel_clock_in);
   endtask
endmodule // scan_ctrl_model

// [tb.sv]
`timescale 1ns/10ps
`include "afe_defs.vh"
`define CHK(nm, e, g) begin n_checks++; if ((e) !== (g)) begin fails++; \
   $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tb;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, adc_valid = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, exp_w;
   logic [1:0]  htrans = 2'h0;
   logic [13:0] adc_result = 14'h0;
   wire         hready, hreadyout, hresp, adc_ready, clamp_active, cds_enable, output_slow_slew;
   wire  [31:0] hrdata;
   wire  [7:0]  output_byte_pins;
   wire         output_high_byte, pixel_clock_in, sample_strobe, clamp_request, serial_data_in;
   wire         serial_frame_enable, serial_shift_clock, serial_data_out, serial_data_out_oe;
   int          fails = 0, n_checks = 0, cnt, on, dv;
   logic [8:0]  sq[$], exp_b;
   logic [31:0] rq[$];
   logic        rd_dp = 1'b0, prev_flag = 1'b0, edge_sel = 1'b0, saw_full;
   logic [7:0]  rd;
   realtime     t_rise = 0, t_fall = 0, age;
   assign hready = hreadyout;
   always #12.5 hclk = ~hclk;
   always @(posedge pixel_clock_in) t_rise = $realtime;
   always @(negedge pixel_clock_in) t_fall = $realtime;
   afe_clamp_and_sample_mode_control u_afe_clamp_and_sample_mode_control
   (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata,
      .hreadyout, .hresp, .pixel_clock_in, .sample_strobe, .clamp_request, .serial_frame_enable,
      .serial_shift_clock, .serial_data_in, .serial_data_out, .serial_data_out_oe, .adc_result,
      .adc_valid, .adc_ready, .clamp_active, .cds_enable, .output_slow_slew, .output_byte_pins,
      .output_high_byte
   );
   scan_ctrl_model u_scan_ctrl_model
   (
      .pixel_clock_in, .sample_strobe, .clamp_request, .serial_frame_enable, .serial_shift_clock,
      .serial_data_in, .serial_data_out, .serial_data_out_oe
   );
   task give_verdict;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task timeout;
      fails++;
      give_verdict();
   endtask
   task ahb(input logic [31:0] a, input logic w, input logic [31:0] d);
      int i;
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'h2;
      for (int p = 0; p < 2; p++)
      begin
         i = 0;
         do
         begin
            @(posedge hclk);
            i++;
         end
         while (hready !== 1'b1 && i < 64);
         if (hready !== 1'b1)
            timeout();
         hsel   <= 1'b0;
         htrans <= 2'h0;
         hwdata <= d;
      end
   endtask
   task ahb_read(input logic [31:0] a, input logic [31:0] e);
      rq.push_back(e);
      ahb(a, 1'b0, 32'h0);
   endtask
   task push(input logic [13:0] r);
      int i;
      i = 0;
      @(posedge hclk);
      adc_result <= r;
      adc_valid  <= 1'b1;
      do
      begin
         @(posedge hclk);
         i++;
         if (adc_ready !== 1'b1)
            saw_full = 1'b1;
      end
      while (adc_ready !== 1'b1 && i < 400);
      if (adc_ready !== 1'b1)
         timeout();
      sq.push_back({1'b1, r[13:6]});
      sq.push_back({1'b0, r[5:0], 2'h0});
      adc_valid <= 1'b0;
   endtask
   task wait_drain;
      for (int i = 0; i < 5000 && sq.size() > 0; i++)
         @(posedge hclk);
      repeat (40) @(posedge hclk);
      if (sq.size() > 0)
         timeout();
   endtask
   task count_clamp(input int n);
      cnt = 0;
      repeat (n) @(posedge hclk) cnt += (clamp_active === 1'b1);
   endtask
   // Read data phase watcher
   always @(posedge hclk)
   begin
      if (rd_dp && hready === 1'b1)
      begin
         exp_w = rq.pop_front();
         `CHK("hrdata", exp_w, hrdata)
         `CHK("hresp", 1'b0, hresp)
      end
      if (hready === 1'b1)
         rd_dp <= hsel && htrans[1] && !hwrite;
   end
   // Output byte watcher, one note per byte
   always @(posedge hclk)
   begin
      if (hresetn && output_high_byte !== prev_flag)
      begin
         prev_flag <= output_high_byte;
         age = $realtime - (edge_sel ? t_rise : t_fall);
         exp_b = (sq.size() > 0) ? sq.pop_front() : 9'h1FF;
         `CHK("byte", exp_b, {output_high_byte, output_byte_pins})
         `CHK("edge", 1'b1, age >= 40 && age <= 140)
      end
   end
   initial
   begin
      void'($urandom(8043));
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      ahb_read(`AFE_CFG_OFFSET, 32'h0);
      ahb_read(`AFE_STAT_OFFSET, 32'h2);
      ahb_read(32'h8, 32'h0);
      u_scan_ctrl_model.ser_frame(16'h0005, rd);
      `CHK("slew", 1'b1, output_slow_slew)
      `CHK("cds", 1'b1, cds_enable)
      u_scan_ctrl_model.ser_frame(16'h010F, rd);
      u_scan_ctrl_model.ser_frame(16'h8000, rd);
      `CHK("serial read", 8'h05, rd)
      ahb_read(`AFE_CFG_OFFSET, 32'h5);
      ahb(`AFE_CFG_OFFSET, 1'b1, 32'h0);
      repeat (3) @(posedge hclk);
      `CHK("slew off", 1'b0, output_slow_slew)
      `CHK("cds off", 1'b0, cds_enable)
      $display("test config done");
      for (int e = 0; e < 2; e++)
      begin
         ahb(`AFE_CFG_OFFSET, 1'b1, 32'(e) << `AFE_CFG_EDGE_SEL);
         edge_sel <= e[0];
         saw_full = 1'b0;
         repeat (e ? 4 : 40) push(14'($urandom));
         `CHK("fifo refused", e == 0, saw_full)
         wait_drain();
         ahb_read(`AFE_STAT_OFFSET, 32'h2);
         $display("test stream %0d done", e);
      end
      for (int k = 0; k < 4; k++)
      begin
         dv = (k < 2) ? 2 : 4;
         on = (k == 3) ? 2 : 1;
         ahb(`AFE_CFG_OFFSET, 1'b1, 32'(k % 2) << `AFE_CFG_CLAMP_PHASE);
         u_scan_ctrl_model.div = dv;
         u_scan_ctrl_model.clamp_on = 1'b1;
         repeat (dv * 32) @(posedge hclk);
         count_clamp(dv * 32);
         `CHK("clamp duty", on * 32, cnt)
         u_scan_ctrl_model.clamp_on = 1'b0;
         repeat (dv * 24) @(posedge hclk);
         count_clamp(dv * 16);
         `CHK("clamp idle", 0, cnt)
         ahb_read(`AFE_STAT_OFFSET, 32'(dv));
         $display("test clamp %0d done", k);
      end
      give_verdict();
   end
endmodule // tb
